// File: ufa_pkg.sv
/*
  Shared constants for the receive frame-error and address-match block.
  Assumes a synchronous special function register port and one core clock.
*/
`default_nettype none
package ufa_pkg;
  // ************************************************
  // Register map and reset values
  // ************************************************
  localparam logic [7:0] ADDR_SLAVE_VALUE = 8'h00A9;
  localparam logic [7:0] ADDR_SLAVE_MASK  = 8'h00B9;
  localparam logic [7:0] RST_SLAVE_VALUE  = 8'h0000;
  localparam logic [7:0] RST_SLAVE_MASK   = 8'h0000;
  localparam logic [7:0] RD_UNMAPPED      = 8'h0000;
  // ************************************************
  // Frame word layout: {stopOk, ninth, data[7:0]}
  // ************************************************
  localparam int FRAME_W   = 10;
  localparam int POS_NINTH = 8;
  localparam int POS_STOP  = 9;
  localparam int BUF_DEPTH = 2;
  // ************************************************
  // Serial modes
  // ************************************************
  typedef enum logic [1:0] {
    UFA_MODE_SHIFT,
    UFA_MODE_8BIT,
    UFA_MODE_9BIT_FIX,
    UFA_MODE_9BIT_VAR
  } ufa_mode_e;
endpackage : ufa_pkg
`default_nettype wire

// File: ufa_buf_if.sv
/*
  Valid/ready carrier between the receive core and its frame buffer.
  Assumes both ends share core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface ufa_buf_if;
  import ufa_pkg::*;
  logic               inValid;
  logic               inReady;
  logic [FRAME_W-1:0] inData;
  logic               outValid;
  logic               outReady;
  logic [FRAME_W-1:0] outData;
  modport store (input inValid, inData, outReady, output inReady, outValid, outData);
  modport user  (output inValid, inData, outReady, input inReady, outValid, outData);
endinterface : ufa_buf_if
`default_nettype wire

// File: ufa_buf.sv
/*
  Two-entry frame buffer with valid and ready on both sides.
  Assumes synchronous active-low reset on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ufa_buf
  import ufa_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Buffer ports
  ufa_buf_if.store bus
);
  logic [FRAME_W-1:0] mem_reg [BUF_DEPTH];
  logic               wrPtr_reg;
  logic               rdPtr_reg;
  logic [1:0]         count_reg;
  logic [1:0]         count_next;
  wire                push = bus.inValid && bus.inReady;
  wire                pop  = bus.outValid && bus.outReady;

  // Honest full and empty: ready drops only when both entries hold words
  assign bus.inReady  = (count_reg != 2'(BUF_DEPTH));
  assign bus.outValid = (count_reg != 2'h0);
  assign bus.outData  = mem_reg[rdPtr_reg];
  assign count_next   = count_reg + 2'(push) - 2'(pop);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wrPtr_reg <= 1'b0;
      rdPtr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      wrPtr_reg <= wrPtr_reg ^ push;
      rdPtr_reg <= rdPtr_reg ^ pop;
      count_reg <= count_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_reg[wrPtr_reg] <= bus.inData;
    end
  end
endmodule : ufa_buf
`default_nettype wire

// File: ufa_rx_addr.sv
/*
  Receive-side frame error flag and multiprocessor address recognition.
  Assumes the bit-level receiver delivers one word per finished frame and
  that the rest of the serial control register lives elsewhere.
*/
// Overview of operation
// - A frame that arrives without a valid stop bit sets the frame error flag.
// - Control bit 7 shows the frame error flag when view select is 1 and mode select high when it is 0.
// - Only hardware sets the frame error flag, only a software write clears it, and good frames leave it set.
// - In the 9-bit modes address bytes carry a high ninth bit and data bytes a low one.
// - With the address filter enabled in modes 1 to 3, receive done rises only for a given or broadcast address match; mode 0 takes every frame.
// - With the address filter disabled, receive done rises for every complete frame.
// - In mode 1 with the filter enabled, receive done needs both a valid stop bit and an address match.
// - The given address compares only the slave address bits whose mask bits are 1.
// - The broadcast address is slave address OR mask, its zero bits being don't care.
// - Slave address sits at A9h and mask at B9h, both readable and writable.
// - Reset clears slave address and mask to 00h so every address byte matches.
// - At frame end data and ninth bit load and receive done rises only if it was clear and the filter is off or the ninth bit is 1 and the address matches.
// - In the 9-bit modes the received ninth bit goes to the received ninth bit field.
`timescale 1ns/1ps
`default_nettype none
module ufa_rx_addr
  import ufa_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // Special function register port
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrEn,
  input  wire logic       sfrRdEn,
  input  wire logic [7:0] sfrWrData,
  output logic      [7:0] sfrRdData,
  // Shared control bit 7
  input  wire logic       bit7WrEn,
  input  wire logic       bit7WrData,
  output logic            bit7RdData,
  // Other control bits
  input  wire logic       viewSelectBit,
  input  wire logic       modeSelectLow,
  input  wire logic       addressFilterEnable,
  input  wire logic       receiveDoneClear,
  // Frame word from the bit receiver
  input  wire logic       frameValid,
  output logic            frameReady,
  input  wire logic [7:0] frameData,
  input  wire logic       frameNinth,
  input  wire logic       frameStopOk,
  // Receive results
  output logic            modeSelectHigh,
  output logic            frameErrorFlag,
  output logic            receiveDoneFlag,
  output logic            receivedNinthBit,
  output logic      [7:0] rxData
);
  // ************************************************
  // Registers
  // ************************************************
  logic [7:0] slaveAddrValue_reg;
  logic [7:0] slaveAddrMask_reg;
  logic [7:0] rdData_reg;
  logic       modeHigh_reg;
  logic       frameErr_reg;
  logic       frameErr_next;
  logic       rxDone_reg;
  logic       rxDone_next;
  logic       ninth_reg;
  logic [7:0] rxData_reg;

  // ************************************************
  // Frame buffer
  // ************************************************
  ufa_buf_if fb ();

  ufa_buf u_buf (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .bus      (fb.store)
  );

  assign fb.inValid = frameValid;
  assign fb.inData  = {frameStopOk, frameNinth, frameData};
  assign frameReady = fb.inReady;

  // Words wait while receive done is set, so a slow reader stalls the
  // receiver instead of losing frames
  assign fb.outReady = !rxDone_reg;

  // ************************************************
  // Address recognition
  // ************************************************
  function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] val, input logic [7:0] msk);
    logic [7:0] bcast;
    bcast    = val | msk;
    addr_hit = (((rx ^ val) & msk) == 8'h00) || (((rx ^ bcast) & bcast) == 8'h00);
  endfunction

  ufa_mode_e  mode;
  wire        pop       = fb.outValid && fb.outReady;
  wire [7:0]  popData   = fb.outData[7:0];
  wire        popNinth  = fb.outData[POS_NINTH];
  wire        popStopOk = fb.outData[POS_STOP];
  wire        nineBit   = (mode == UFA_MODE_9BIT_FIX) || (mode == UFA_MODE_9BIT_VAR);
  wire        modeOne   = (mode == UFA_MODE_8BIT);
  // Mode 1 uses the stop bit as its ninth bit
  wire        tagBit    = nineBit ? popNinth : popStopOk;
  wire        match     = addr_hit(popData, slaveAddrValue_reg, slaveAddrMask_reg);
  wire        filterOn  = addressFilterEnable && (nineBit || modeOne);
  wire        accept    = pop && (!filterOn || (tagBit && match));

  assign mode = ufa_mode_e'({modeHigh_reg, modeSelectLow});

  // ************************************************
  // Flags; a hardware set beats a same-cycle clear
  // ************************************************
  wire feWrite = bit7WrEn && viewSelectBit;
  wire feSet   = pop && !popStopOk;

  // A software write of 1 cannot set the error flag
  assign frameErr_next = feSet || (frameErr_reg && !(feWrite && !bit7WrData));
  assign rxDone_next   = accept || (rxDone_reg && !receiveDoneClear);

  // ************************************************
  // Register port decode
  // ************************************************
  wire selValue = (sfrAddr == ADDR_SLAVE_VALUE);
  wire selMask  = (sfrAddr == ADDR_SLAVE_MASK);
  wire [7:0] rdMux = selValue ? slaveAddrValue_reg :
                     selMask  ? slaveAddrMask_reg  : RD_UNMAPPED;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      slaveAddrValue_reg <= RST_SLAVE_VALUE;
      slaveAddrMask_reg  <= RST_SLAVE_MASK;
      rdData_reg         <= RD_UNMAPPED;
    end else begin
      if (sfrWrEn && selValue) begin
        slaveAddrValue_reg <= sfrWrData;
      end
      if (sfrWrEn && selMask) begin
        slaveAddrMask_reg <= sfrWrData;
      end
      if (sfrRdEn) begin
        rdData_reg <= rdMux;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      modeHigh_reg <= 1'b0;
      frameErr_reg <= 1'b0;
      rxDone_reg   <= 1'b0;
    end else begin
      if (bit7WrEn && !viewSelectBit) begin
        modeHigh_reg <= bit7WrData;
      end
      frameErr_reg <= frameErr_next;
      rxDone_reg   <= rxDone_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ninth_reg  <= 1'b0;
      rxData_reg <= 8'h00;
    end else if (accept) begin
      ninth_reg  <= tagBit;
      rxData_reg <= popData;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign bit7RdData       = viewSelectBit ? frameErr_reg : modeHigh_reg;
  assign sfrRdData        = rdData_reg;
  assign modeSelectHigh   = modeHigh_reg;
  assign frameErrorFlag   = frameErr_reg;
  assign receiveDoneFlag  = rxDone_reg;
  assign receivedNinthBit = ninth_reg;
  assign rxData           = rxData_reg;

  // ************************************************
  // Assertions
  // ************************************************
  a_fe_bad_stop: assert property (@(posedge core_clk) disable iff (!rst_b)
    pop && !popStopOk |=> frameErrorFlag)
    else $error("frame error flag not set after bad stop bit");

  a_fe_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
    frameErrorFlag && !(bit7WrEn && viewSelectBit && !bit7WrData) |=> frameErrorFlag)
    else $error("frame error flag dropped without software clear");

  a_fe_hw_only: assert property (@(posedge core_clk) disable iff (!rst_b)
    !frameErrorFlag && !(pop && !popStopOk) |=> !frameErrorFlag)
    else $error("frame error flag set without a bad frame");

  a_bit7_view: assert property (@(posedge core_clk) disable iff (!rst_b)
    bit7WrEn && !viewSelectBit ##1 !bit7WrEn && !viewSelectBit |-> bit7RdData == $past(bit7WrData))
    else $error("mode select high not seen through bit 7");

  a_open_accept: assert property (@(posedge core_clk) disable iff (!rst_b)
    pop && !addressFilterEnable |=> receiveDoneFlag && rxData == $past(popData))
    else $error("frame dropped with filter off");

  a_filter_drop: assert property (@(posedge core_clk) disable iff (!rst_b)
    pop && addressFilterEnable && nineBit && !addr_hit(popData, slaveAddrValue_reg, slaveAddrMask_reg)
    |=> !receiveDoneFlag)
    else $error("receive done raised for foreign address");

  a_mode1_stop: assert property (@(posedge core_clk) disable iff (!rst_b)
    pop && addressFilterEnable && modeOne && !popStopOk |=> !receiveDoneFlag)
    else $error("mode 1 frame accepted without stop bit");

  a_ninth_load: assert property (@(posedge core_clk) disable iff (!rst_b)
    accept && nineBit |=> receivedNinthBit == $past(popNinth))
    else $error("ninth bit not loaded");

  a_hold_full: assert property (@(posedge core_clk) disable iff (!rst_b)
    receiveDoneFlag && !receiveDoneClear |=> $stable(rxData) && $stable(receivedNinthBit))
    else $error("receive data overwritten while done flag set");

  a_addr_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    sfrWrEn && selMask |=> slaveAddrMask_reg == $past(sfrWrData))
    else $error("mask register write lost");

  // Bus tasks start one cycle after release, so the first read lands two edges in
  a_reset_regs: assert property (@(posedge core_clk)
    !rst_b ##1 rst_b ##1 rst_b && sfrRdEn && sfrAddr == ADDR_SLAVE_VALUE && !sfrWrEn |=> sfrRdData == 8'h00)
    else $error("slave address not cleared by reset");
endmodule : ufa_rx_addr
`default_nettype wire

// File: ufa_frame_src.sv
/*
  Far-side model: the bit receiver handing finished frame words to the block.
  Assumes valid/ready on core_clk; the testbench calls send() right after an edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ufa_frame_src (
  // Clock and handshake
  input  wire logic       core_clk,
  input  wire logic       frameReady,
  // Frame word
  output logic            frameValid,
  output logic      [7:0] frameData,
  output logic            frameNinth,
  output logic            frameStopOk
);
  initial begin
    frameValid = 1'b0;
    {frameStopOk, frameNinth, frameData} = 10'h0000;
  end
  // Word held until taken; released lines show the inverse so stale data never looks valid
  task automatic send(input logic [9:0] w);
    logic rdy;
    #1 frameValid = 1'b1;
    {frameStopOk, frameNinth, frameData} = w;
    forever begin
      rdy = frameReady;
      @(posedge core_clk);
      if (rdy) break;
      #1;
    end
    #1 frameValid = 1'b0;
    {frameStopOk, frameNinth, frameData} = ~w;
  endtask
endmodule // ufa_frame_src
`default_nettype wire

// File: testbench.sv
/*
  Self-checking bench for the frame error and address match block.
  Assumes ufa_pkg and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ufa_pkg::*;
  logic core_clk = 1'b0, rst_b = 1'b0;
  logic [7:0] sfrAddr = 8'h0000, sfrWrData = 8'h0000, sfrRdData, rxData, frameData;
  logic sfrWrEn = 0, sfrRdEn = 0, bit7WrEn = 0, bit7WrData = 0, bit7RdData;
  logic viewSelectBit = 0, modeSelectLow = 0, addressFilterEnable = 0, receiveDoneClear = 0;
  logic frameValid, frameReady, frameNinth, frameStopOk;
  logic modeSelectHigh, frameErrorFlag, receiveDoneFlag, receivedNinthBit;
  int num_errors = 0, checks_done = 0;
  always #20 core_clk = ~core_clk;
  ufa_rx_addr dut (.core_clk, .rst_b, .sfrAddr, .sfrWrEn, .sfrRdEn, .sfrWrData, .sfrRdData,
    .bit7WrEn, .bit7WrData, .bit7RdData, .viewSelectBit, .modeSelectLow, .addressFilterEnable,
    .receiveDoneClear, .frameValid, .frameReady, .frameData, .frameNinth, .frameStopOk,
    .modeSelectHigh, .frameErrorFlag, .receiveDoneFlag, .receivedNinthBit, .rxData);
  ufa_frame_src src (.core_clk, .frameReady, .frameValid, .frameData, .frameNinth, .frameStopOk);
  // ************************************************
  // Access tasks
  // ************************************************
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1 {sfrAddr, sfrWrData, sfrWrEn} = {a, d, 1'b1};
    @(posedge core_clk) #1 sfrWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge core_clk) #1 {sfrAddr, sfrRdEn} = {a, 1'b1};
    @(posedge core_clk) #1 sfrRdEn = 1'b0;
    chk(n, sfrRdData, e);
  endtask
  task automatic b7(input logic v, input logic d);
    @(posedge core_clk) #1 {viewSelectBit, bit7WrData, bit7WrEn} = {v, d, 1'b1};
    @(posedge core_clk) #1 bit7WrEn = 1'b0;
  endtask
  // Waits a bounded time for receive done, checks the result, then clears the flag
  task automatic done(input logic e, input logic [9:0] w);
    for (int i = 0; i < 8 && receiveDoneFlag !== 1'b1; i++) @(posedge core_clk) #1;
    chk("receive done", receiveDoneFlag, e);
    if (e) begin
      chk("rx data", rxData, w[7:0]);
      chk("ninth bit", receivedNinthBit, w[8]);
    end
    @(posedge core_clk) #1 receiveDoneClear = 1'b1;
    @(posedge core_clk) #1 receiveDoneClear = 1'b0;
  endtask
  task automatic recv(input logic [9:0] w, input logic e);
    @(posedge core_clk);
    src.send(w);
    done(e, w);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ************************************************
  // Tests
  // ************************************************
  initial begin
    #(40 * 4000);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    #1 rst_b = 1'b1;
    rd(ADDR_SLAVE_VALUE, 8'h0000, "value reset");
    rd(ADDR_SLAVE_MASK, 8'h0000, "mask reset");
    rd(8'h00AA, 8'h0000, "unmapped");
    b7(1'b0, 1'b1);
    chk("bit7 mode view", bit7RdData, 1'b1);
    chk("mode high", modeSelectHigh, 1'b1);
    #0 addressFilterEnable = 1'b1;
    // Good stop bits here, so only the bad frame below can raise the error flag
    recv(10'h033C, 1'b1);
    $display("test reset done");
    wr(ADDR_SLAVE_VALUE, 8'h00A4);
    wr(ADDR_SLAVE_MASK, 8'h00FA);
    rd(ADDR_SLAVE_VALUE, 8'h00A4, "value");
    rd(ADDR_SLAVE_MASK, 8'h00FA, "mask");
    recv(10'h03A0, 1'b1);
    recv(10'h03A3, 1'b0);
    recv(10'h03FF, 1'b1);
    recv(10'h02A0, 1'b0);
    #0 addressFilterEnable = 1'b0;
    recv(10'h0255, 1'b1);
    $display("test address done");
    // Three words back to back: the second waits while receive done is set, the third fills the buffer
    @(posedge core_clk);
    src.send(10'h0211);
    src.send(10'h0322);
    src.send(10'h0333);
    repeat (4) @(posedge core_clk);
    #1 chk("held data", rxData, 8'h0011);
    chk("buffer full", frameReady, 1'b0);
    done(1'b1, 10'h0211);
    done(1'b1, 10'h0322);
    done(1'b1, 10'h0333);
    $display("test blocking done");
    b7(1'b0, 1'b0);
    #0 {modeSelectLow, addressFilterEnable} = 2'b11;
    chk("error before bad frame", frameErrorFlag, 1'b0);
    recv(10'h01A0, 1'b0);
    b7(1'b1, 1'b1);
    chk("error view", bit7RdData, 1'b1);
    // Mode 1 hands back the stop bit as its ninth bit
    recv(10'h03A0, 1'b1);
    chk("error sticky", frameErrorFlag, 1'b1);
    b7(1'b1, 1'b0);
    chk("error cleared", frameErrorFlag, 1'b0);
    b7(1'b0, 1'b1);
    chk("mode view", bit7RdData, 1'b1);
    chk("error untouched", frameErrorFlag, 1'b0);
    $display("test frame error done");
    recv(10'h03A3, 1'b0);
    b7(1'b0, 1'b0);
    #0 modeSelectLow = 1'b0;
    recv(10'h03A3, 1'b1);
    $display("test modes done");
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
